/* rtl/bre_pkg.sv */
// block request engine package: request, backend and completion carriers,
// request codes, status codes, register offsets and reset values.
// assumes a single 100 MHz clock domain shared by every user of these types.
package bre_pkg;

   // ==========================================================
   // request type codes (low bits of the type word)
   localparam logic [31:0] TYPE_READ      = 32'h0000_0000;
   localparam logic [31:0] TYPE_WRITE     = 32'h0000_0001;
   localparam logic [31:0] TYPE_SCSI      = 32'h0000_0002;
   localparam logic [31:0] TYPE_SCSI_OUT  = 32'h0000_0003;
   localparam logic [31:0] TYPE_FLUSH     = 32'h0000_0004;
   localparam logic [31:0] TYPE_FLUSH_OUT = 32'h0000_0005;
   localparam logic [31:0] TYPE_DISCARD   = 32'h0000_000B;
   localparam logic [31:0] TYPE_WZEROES   = 32'h0000_000D;
   localparam int          BARRIER_BIT    = 31;
   localparam int          UNMAP_BIT      = 0;

   // ==========================================================
   // final status byte values
   localparam logic [7:0] STS_OK     = 8'h00;
   localparam logic [7:0] STS_IOERR  = 8'h01;
   localparam logic [7:0] STS_UNSUPP = 8'h02;

   // ==========================================================
   // register offsets and reset values
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STAT   = 8'h04;
   localparam logic [9:0] CTRL_RESET = 10'h002;

   // ==========================================================
   // carriers
   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_WRITE = 3'h1,
      OP_FLUSH = 3'h2,
      OP_DISC  = 3'h3,
      OP_ZERO  = 3'h4,
      OP_SCSI  = 3'h5
   } bre_op_t;

   typedef struct packed {
      logic        guest_be;   // legacy guest is big endian
      logic        legacy;     // legacy interface in use
      logic        unmap_cap;  // backend may deallocate ranges
      logic        scsi;       // scsi packet commands offered
      logic        barrier;    // barrier bit honoured
      logic        writeback;  // cache mode, 1 = writeback
      logic        wce_neg;    // cache mode control negotiated
      logic        flush_neg;  // flush negotiated
      logic        flush_off;  // flush offered
      logic        ro;         // read-only offered
   } bre_ctrl_t;

   typedef struct packed {
      logic [31:0] type_w;     // type word
      logic [63:0] sector;     // start sector, 512-byte units
      logic [31:0] nsect;      // sector count (segment num_sectors)
      logic [31:0] seg_flags;  // segment flags word
      logic [15:0] cmd_len;    // scsi command buffer length
      logic [31:0] data_len;   // data bytes of the request
   } bre_req_t;

   typedef struct packed {
      bre_op_t     op;
      logic [63:0] sector;
      logic [31:0] nsect;
      logic        commit;     // persist before done
      logic        dealloc;    // range may be released
      logic [15:0] cmd_len;
      logic [31:0] data_len;
   } bre_be_cmd_t;

   typedef struct packed {
      logic        err;
      logic [31:0] xfer;       // bytes actually moved
      logic [7:0]  sense;      // sense bytes actually written
   } bre_be_rsp_t;

   typedef struct packed {
      logic [7:0]  status;
      logic [31:0] sense_len;
      logic [31:0] residual;
   } bre_cpl_t;

endpackage

/* rtl/bre_engine.sv */
// block request engine: decodes guest block requests, drives the backend
// storage port and returns a completion with the final status byte.
// assumes one clock, synchronous reset, and a backend that answers each
// accepted command with exactly one done pulse.
//
// Summary of operation
// - read-only device fails writes, touches nothing
// - unknown segment flags give unsupported status
// - discard with unmap gives unsupported status
// - discard may release backend allocation
// - write-zeroes with unmap may release allocation
// - write-zeroes always leaves sectors reading zero
// - may-unmap indication cleared when unmap impossible
// - indication change raises configuration notification
// - three conditions make a completed write stable
// - stable writes committed before completion reported
// - writeback change mid-write: either outcome allowed
// - legacy header fields in guest byte order
// - type five handled exactly as flush
// - barrier waits for earlier, blocks later
// - scsi types two and three treated identically
// - scsi command length from its buffer
// - sense length reports bytes actually written
// - residual is data length minus transferred
// - status byte zero ok, one error, two unsupported
// - type codes read, write, flush, discard, zeroes
// - segment holds sector, count, flags with unmap
`timescale 1ns/1ps
module bre_engine (
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   // register port
   input  wire logic [7:0]           reg_addr_i,
   input  wire logic [31:0]          reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output logic      [31:0]          reg_rdata_o,
   // request side
   input  wire logic                 req_valid_i,
   input  wire bre_pkg::bre_req_t    req_i,
   output logic                      req_ready_o,
   // backend side
   output logic                      be_valid_o,
   output bre_pkg::bre_be_cmd_t      be_cmd_o,
   input  wire logic                 be_ready_i,
   input  wire logic                 be_done_i,
   input  wire bre_pkg::bre_be_rsp_t be_rsp_i,
   // completion side
   output logic                      cpl_valid_o,
   output bre_pkg::bre_cpl_t         cpl_o,
   // configuration indications
   output logic                      wz_may_unmap_o,
   output logic                      cfg_change_o
);
   import bre_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DEC   = 2'b01,
      ST_ISSUE = 2'b11,
      ST_WAIT  = 2'b10
   } bre_state_t;

   // ==========================================================
   // byte order helpers
   function automatic logic [31:0] swap32(input logic [31:0] v);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         r[8*i +: 8] = v[8*(3-i) +: 8];
      end
      return r;
   endfunction

   function automatic logic [63:0] swap64(input logic [63:0] v);
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[8*i +: 8] = v[8*(7-i) +: 8];
      end
      return r;
   endfunction

   // ==========================================================
   // state
   bre_state_t  st_r;
   bre_ctrl_t   ctrl_r;
   bre_req_t    req_r;
   bre_op_t     cur_op_r;
   logic        dirty_r;
   logic [15:0] done_cnt_r;
   logic        req_ready_r;
   logic        be_valid_r;
   bre_be_cmd_t be_cmd_r;
   logic        cpl_valid_r;
   bre_cpl_t    cpl_r;
   logic        wz_unmap_r;
   logic        cfg_chg_r;
   logic [31:0] rdata_r;

   // ==========================================================
   // decode of the captured request
   logic [31:0] tw;
   logic [31:0] base_t;
   logic [63:0] sec;
   logic [31:0] nsec;
   logic [31:0] flg;
   logic        swap_en;
   logic        is_rd;
   logic        is_wr;
   logic        is_fl;
   logic        is_disc;
   logic        is_wz;
   logic        is_scsi;
   logic        stable_now;
   logic        reject;
   logic [7:0]  rej_sts;
   bre_op_t     dec_op;
   logic        dealloc;
   logic [31:0] resid_calc;

   // legacy big-endian guests present header fields byte-swapped
   assign swap_en = ctrl_r.legacy & ctrl_r.guest_be;
   assign tw      = swap_en ? swap32(req_r.type_w)    : req_r.type_w;
   assign sec     = swap_en ? swap64(req_r.sector)    : req_r.sector;
   assign nsec    = swap_en ? swap32(req_r.nsect)     : req_r.nsect;
   assign flg     = swap_en ? swap32(req_r.seg_flags) : req_r.seg_flags;

   // barrier bit stripped only when the feature is on, else unknown type
   assign base_t  = ctrl_r.barrier ? {1'b0, tw[30:0]} : tw;
   assign is_rd   = (base_t == TYPE_READ);
   assign is_wr   = (base_t == TYPE_WRITE);
   assign is_fl   = (base_t == TYPE_FLUSH) || (base_t == TYPE_FLUSH_OUT);
   assign is_disc = (base_t == TYPE_DISCARD);
   assign is_wz   = (base_t == TYPE_WZEROES);
   assign is_scsi = ctrl_r.scsi && ((base_t == TYPE_SCSI) || (base_t == TYPE_SCSI_OUT));

   // cases one and two; case three is the dirty flag cleared by flush.
   // commit is fixed at issue, so a writeback flip mid-write leaves that write's commit unchanged
   assign stable_now = (ctrl_r.flush_off && !ctrl_r.flush_neg && !ctrl_r.wce_neg)
                     || (ctrl_r.wce_neg && !ctrl_r.writeback);

   // dealloc only where the backend can release ranges
   assign dealloc = ctrl_r.unmap_cap && (is_disc || (is_wz && flg[UNMAP_BIT]));

   // rejection decision and status code
   always_comb begin
      reject  = 1'b0;
      rej_sts = STS_OK;
      dec_op  = OP_READ;
      if (is_rd) begin
         dec_op = OP_READ;
      end else if (is_wr) begin
         dec_op = OP_WRITE;
         if (ctrl_r.ro) begin
            reject  = 1'b1;
            rej_sts = STS_IOERR;
         end
      end else if (is_fl) begin
         dec_op = OP_FLUSH;
      end else if (is_disc || is_wz) begin
         dec_op = is_disc ? OP_DISC : OP_ZERO;
         if (|flg[31:1] || (is_disc && flg[UNMAP_BIT])) begin
            reject  = 1'b1;
            rej_sts = STS_UNSUPP;
         end
      end else if (is_scsi) begin
         dec_op = OP_SCSI;
      end else begin
         reject  = 1'b1;
         rej_sts = STS_UNSUPP;
      end
   end

   assign resid_calc = req_r.data_len - be_rsp_i.xfer;

   // ==========================================================
   // request sequencer; one request in flight keeps barriers trivially
   // ordered at the cost of no overlap between requests
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_r        <= ST_IDLE;
         req_ready_r <= 1'b1;
         req_r       <= '0;
         cur_op_r    <= OP_READ;
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (req_valid_i) begin
                  req_r       <= req_i;
                  req_ready_r <= 1'b0;
                  st_r        <= ST_DEC;
               end
            end
            ST_DEC: begin
               cur_op_r <= dec_op;
               if (reject) begin
                  req_ready_r <= 1'b1;
                  st_r        <= ST_IDLE;
               end else begin
                  st_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               if (be_ready_i) begin
                  st_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (be_done_i) begin
                  req_ready_r <= 1'b1;
                  st_r        <= ST_IDLE;
               end
            end
            default: begin
               st_r        <= ST_IDLE;
               req_ready_r <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // backend command; a rejected write never reaches the backend
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         be_valid_r <= 1'b0;
         be_cmd_r   <= '0;
      end else if (st_r == ST_DEC && !reject) begin
         be_valid_r        <= 1'b1;
         be_cmd_r.op       <= dec_op;
         be_cmd_r.sector   <= sec;
         be_cmd_r.nsect    <= nsec;
         be_cmd_r.commit   <= is_fl || (is_wr && stable_now);
         be_cmd_r.dealloc  <= dealloc;
         be_cmd_r.cmd_len  <= req_r.cmd_len;
         be_cmd_r.data_len <= req_r.data_len;
      end else if (st_r == ST_ISSUE && be_ready_i) begin
         be_valid_r <= 1'b0;
      end
   end

   // ==========================================================
   // completion, raised after the backend reports done, or straight from decode for a rejected request
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cpl_valid_r <= 1'b0;
         cpl_r       <= '0;
      end else if (st_r == ST_DEC && reject) begin
         cpl_valid_r     <= 1'b1;
         cpl_r.status    <= rej_sts;
         cpl_r.sense_len <= '0;
         cpl_r.residual  <= req_r.data_len;
      end else if (st_r == ST_WAIT && be_done_i) begin
         cpl_valid_r     <= 1'b1;
         cpl_r.status    <= be_rsp_i.err ? STS_IOERR : STS_OK;
         cpl_r.sense_len <= (cur_op_r == OP_SCSI) ? {24'h00_0000, be_rsp_i.sense} : 32'h0000_0000;
         cpl_r.residual  <= (cur_op_r == OP_SCSI) ? resid_calc : 32'h0000_0000;
      end else begin
         cpl_valid_r <= 1'b0;
      end
   end

   // ==========================================================
   // volatile data tracking: a cached write is dirty until a flush lands
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         dirty_r    <= 1'b0;
         done_cnt_r <= '0;
      end else if (st_r == ST_WAIT && be_done_i) begin
         done_cnt_r <= done_cnt_r + 16'h0001;
         if (cur_op_r == OP_FLUSH && !be_rsp_i.err) begin
            dirty_r <= 1'b0;
         end else if (cur_op_r == OP_WRITE && !be_cmd_r.commit) begin
            dirty_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // may-unmap indication follows backend capability, change notified
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         wz_unmap_r <= 1'b0;
         cfg_chg_r  <= 1'b0;
      end else begin
         wz_unmap_r <= ctrl_r.unmap_cap;
         cfg_chg_r  <= (ctrl_r.unmap_cap != wz_unmap_r);
      end
   end

   // ==========================================================
   // register port: writes land next edge, reads answer one cycle later
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_r <= CTRL_RESET;
      end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
         ctrl_r <= reg_wdata_i[9:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_r <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            REG_CTRL: rdata_r <= {22'h00_0000, ctrl_r};
            REG_STAT: rdata_r <= {done_cnt_r, 10'h000, st_r, 1'b0, wz_unmap_r, dirty_r, (st_r != ST_IDLE)};
            default:  rdata_r <= 32'h0000_0000;   // unmapped reads as zero
         endcase
      end
   end

   // outputs straight from flops
   assign reg_rdata_o    = rdata_r;
   assign req_ready_o    = req_ready_r;
   assign be_valid_o     = be_valid_r;
   assign be_cmd_o       = be_cmd_r;
   assign cpl_valid_o    = cpl_valid_r;
   assign cpl_o          = cpl_r;
   assign wz_may_unmap_o = wz_unmap_r;
   assign cfg_change_o   = cfg_chg_r;

   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_ro_write_err: assert property ((st_r == ST_DEC) && is_wr && ctrl_r.ro |=>
      cpl_valid_o && (cpl_o.status == STS_IOERR) && !be_valid_o ##1 !be_valid_o)
      else $error("read-only write not failed cleanly");

   a_flag_unsupp: assert property ((st_r == ST_DEC) && (is_disc || is_wz) && (|flg[31:1]) |=>
      cpl_valid_o && (cpl_o.status == STS_UNSUPP))
      else $error("unknown segment flag not unsupported");

   a_disc_unmap: assert property ((st_r == ST_DEC) && is_disc && flg[UNMAP_BIT] |=>
      cpl_valid_o && (cpl_o.status == STS_UNSUPP))
      else $error("discard with unmap not unsupported");

   a_wz_zero_op: assert property ((st_r == ST_DEC) && is_wz && !reject |=>
      be_valid_o && (be_cmd_o.op == OP_ZERO) && (be_cmd_o.dealloc == $past(dealloc)))
      else $error("write zeroes not issued as zero fill");

   a_cfg_notify: assert property ($changed(wz_may_unmap_o) |-> cfg_change_o)
      else $error("may-unmap change without notification");

   a_stable_commit: assert property ((st_r == ST_DEC) && is_wr && !ctrl_r.ro && stable_now |=>
      be_valid_o && be_cmd_o.commit)
      else $error("stable write issued without commit");

   a_flush_alias: assert property ((st_r == ST_DEC) && (base_t == TYPE_FLUSH_OUT) |=>
      be_valid_o && (be_cmd_o.op == OP_FLUSH) && be_cmd_o.commit)
      else $error("type five not handled as flush");

   a_scsi_same: assert property ((st_r == ST_DEC) && is_scsi |=>
      be_valid_o && (be_cmd_o.op == OP_SCSI) && (be_cmd_o.cmd_len == $past(req_r.cmd_len)))
      else $error("scsi type not issued as scsi op");

   a_scsi_resid: assert property ((st_r == ST_WAIT) && be_done_i && (cur_op_r == OP_SCSI) |=>
      (cpl_o.residual == $past(resid_calc)) && (cpl_o.sense_len[7:0] == $past(be_rsp_i.sense)))
      else $error("scsi residual or sense length wrong");

   a_cpl_after_done: assert property (cpl_valid_o |->
      ($past(st_r) == ST_DEC) || (($past(st_r) == ST_WAIT) && $past(be_done_i)))
      else $error("completion without finished data effects");

   a_one_in_flight: assert property ((st_r != ST_IDLE) |-> !req_ready_o)
      else $error("new request taken while one is in flight");

   c_write_ok:   cover property ((cur_op_r == OP_WRITE) && cpl_valid_o && (cpl_o.status == STS_OK));
   c_flush_done: cover property ((cur_op_r == OP_FLUSH) && cpl_valid_o);
   c_rejected:   cover property ((st_r == ST_DEC) && reject ##1 cpl_valid_o);
   c_scsi_done:  cover property ((cur_op_r == OP_SCSI) && cpl_valid_o);

endmodule

/* bench/bre_be_model.sv */
// backend storage model facing the block request engine
// assumes the engine's clock and synchronous active-high reset
`timescale 1ns/1ps
module bre_be_model
   import bre_pkg::*;
(
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   input  wire logic                 be_valid_i,
   input  wire bre_pkg::bre_be_cmd_t be_cmd_i,
   input  wire logic                 slow_i,
   input  wire logic                 err_i,
   output logic                      be_ready_o,
   output logic                      be_done_o,
   output bre_pkg::bre_be_rsp_t      be_rsp_o
);
   logic        busy_r;
   logic [3:0]  cnt_r;
   bre_be_cmd_t cmd_r;
   // =======================================================
   // one command at a time; slow mode stalls ready and done
   always_ff @(posedge mclk_i) begin
      be_done_o <= 1'b0;
      be_rsp_o  <= ~be_rsp_o; // stale response lines keep moving
      if (rst_i) begin
         busy_r     <= 1'b0;
         be_ready_o <= 1'b0;
         cnt_r      <= 4'h0;
         be_rsp_o   <= '0;
      end else if (!busy_r) begin
         be_ready_o <= !slow_i || cnt_r[0];
         cnt_r      <= cnt_r + 4'h1;
         if (be_valid_i && be_ready_o) begin
            busy_r     <= 1'b1;
            be_ready_o <= 1'b0;
            cmd_r      <= be_cmd_i;
            cnt_r      <= slow_i ? 4'h6 : 4'h0;
         end
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end else begin
         // zeroing and commit land before done
         // sense count stays inside the 96-byte sense area
         busy_r    <= 1'b0;
         be_done_o <= 1'b1;
         be_rsp_o  <= {err_i, cmd_r.data_len - ((cmd_r.op == OP_SCSI) ? 32'h10 : 32'h0), 8'h12};
      end
   end
endmodule

/* bench/tb.sv */
// self-checking bench for the block request engine
// assumes the backend model in bre_be_model and a 100 MHz clock
`timescale 1ns/1ps
module tb;
   import bre_pkg::*;
   logic        mclk_i, rst_i, reg_wr_i, reg_rd_i, req_valid_i, be_ready_i, be_done_i;
   logic        req_ready_o, be_valid_o, cpl_valid_o, wz_may_unmap_o, cfg_change_o, slow, err, exp_be, dirty;
   logic [7:0]  reg_addr_i, exp_st;
   logic [31:0] reg_wdata_i, reg_rdata_o, rd;
   bre_req_t    req_i, r;
   bre_be_cmd_t be_cmd_o, got_cmd, exp_cmd;
   bre_be_rsp_t be_rsp_i;
   bre_cpl_t    cpl_o;
   bre_ctrl_t   ctrl;
   int          error_cnt, num_checks, be_cnt, chg_cnt, tgl_cnt;
   logic [31:0] types [9] = '{TYPE_READ, TYPE_WRITE, TYPE_SCSI, TYPE_SCSI_OUT, TYPE_FLUSH,
                              TYPE_FLUSH_OUT, TYPE_DISCARD, TYPE_WZEROES, 32'h7};
   // ctrl, type word, segment flags; second last: writeback zero, the old-device workaround
   logic [73:0] corner [9] = '{{10'h001, TYPE_WRITE, 32'h0}, {10'h0E0, 32'h8000_0003, 32'h0},
      {10'h0E0, TYPE_DISCARD, 32'h1}, {10'h0E0, TYPE_WZEROES, 32'h2}, {10'h0E0, TYPE_WZEROES, 32'h1},
      {10'h300, 32'h0100_0000, 32'h0}, {10'h002, 32'h8000_0000, 32'h0}, {10'h00A, TYPE_WRITE, 32'h0},
      {10'h01E, TYPE_WRITE, 32'h0}};

   bre_engine bre_engine_inst (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .req_valid_i, .req_i, .req_ready_o, .be_valid_o, .be_cmd_o, .be_ready_i,
      .be_done_i, .be_rsp_i, .cpl_valid_o, .cpl_o, .wz_may_unmap_o, .cfg_change_o);
   bre_be_model bre_be_model_inst (.mclk_i, .rst_i, .be_valid_i(be_valid_o), .be_cmd_i(be_cmd_o),
      .slow_i(slow), .err_i(err), .be_ready_o(be_ready_i), .be_done_o(be_done_i), .be_rsp_o(be_rsp_i));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // =======================================================
   // bookkeeping of backend takes and change notifications
   always @(posedge mclk_i) begin
      if (be_valid_o && be_ready_i) begin
         got_cmd <= be_cmd_o;
         be_cnt  <= be_cnt + 1;
      end
      if (cfg_change_o === 1'b1) chg_cnt <= chg_cnt + 1;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(posedge mclk_i);
      rd = reg_rdata_o;
   endtask
   task automatic wctrl(input logic [9:0] v);
      if (v[7] != ctrl.unmap_cap) tgl_cnt++;
      ctrl = bre_ctrl_t'(v);
      wr(REG_CTRL, {22'h0, v});
   endtask
   // =======================================================
   // expected outcome of one request under the current control word
   function automatic void pred(input bre_ctrl_t c, input bre_req_t q);
      logic [31:0] t;
      logic [31:0] f;
      t       = q.type_w;
      f       = q.seg_flags;
      exp_be  = 1'b0;
      exp_st  = STS_UNSUPP;
      exp_cmd = '0;
      exp_cmd.sector = q.sector;
      exp_cmd.nsect  = q.nsect;
      // big-endian legacy guest: every header field arrives byte-swapped
      if (c.legacy && c.guest_be) begin
         t              = {<<8{t}};
         f              = {<<8{f}};
         exp_cmd.sector = {<<8{q.sector}};
         exp_cmd.nsect  = {<<8{q.nsect}};
      end
      if (c.barrier) t[BARRIER_BIT] = 1'b0;
      case (t)
         TYPE_READ: exp_be = 1'b1;
         TYPE_WRITE: begin
            exp_st         = STS_IOERR;
            exp_be         = !c.ro;
            exp_cmd.op     = OP_WRITE;
            exp_cmd.commit = (c.flush_off && !c.flush_neg && !c.wce_neg) || (c.wce_neg && !c.writeback);
         end
         TYPE_FLUSH, TYPE_FLUSH_OUT: begin
            exp_be         = 1'b1;
            exp_cmd.op     = OP_FLUSH;
            exp_cmd.commit = 1'b1;
         end
         TYPE_SCSI, TYPE_SCSI_OUT: begin
            exp_be     = c.scsi;
            exp_cmd.op = OP_SCSI;
         end
         TYPE_DISCARD: begin
            exp_be          = f == 32'h0;
            exp_cmd.op      = OP_DISC;
            exp_cmd.dealloc = c.unmap_cap;
         end
         TYPE_WZEROES: begin
            exp_be          = f[31:1] == 31'h0;
            exp_cmd.op      = OP_ZERO;
            exp_cmd.dealloc = c.unmap_cap && f[UNMAP_BIT];
         end
         default: ;
      endcase
   endfunction
   // the driver side checks status, sense length and residual of each completion
   task automatic run(input bre_req_t q);
      int   n;
      logic sc;
      n = be_cnt;
      pred(ctrl, q);
      req_i       <= q;
      req_valid_i <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         @(posedge mclk_i);
         if (req_ready_o === 1'b1) break;
      end
      req_valid_i <= 1'b0;
      req_i       <= ~q;
      for (int i = 0; i < 64; i++) begin
         @(posedge mclk_i);
         if (cpl_valid_o === 1'b1) break;
      end
      chk(cpl_valid_o, 1'b1);
      chk(be_cnt - n, exp_be);
      sc = exp_be && exp_cmd.op == OP_SCSI;
      if (exp_be) begin
         chk(got_cmd.op, exp_cmd.op);
         if (exp_cmd.op inside {OP_WRITE, OP_FLUSH}) chk(got_cmd.commit, exp_cmd.commit);
         if (exp_cmd.op inside {OP_DISC, OP_ZERO}) chk(got_cmd.dealloc, exp_cmd.dealloc);
         if (sc) chk(got_cmd.cmd_len, q.cmd_len);
         chk(got_cmd.sector, exp_cmd.sector);
         chk(got_cmd.nsect, exp_cmd.nsect);
         exp_st = err ? STS_IOERR : STS_OK;
         // cached write stays volatile until a clean flush lands
         if (exp_cmd.op == OP_FLUSH && !err) dirty = 1'b0;
         if (exp_cmd.op == OP_WRITE && !exp_cmd.commit) dirty = 1'b1;
      end
      chk(cpl_o.status, exp_st);
      chk(cpl_o.sense_len, sc ? 32'h12 : 32'h0);
      chk(cpl_o.residual, sc ? 32'h10 : (exp_be ? 32'h0 : q.data_len));
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // watchdog: the tests need well under half this span
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
   // =======================================================
   // reset, registers, corner requests, then random traffic
   initial begin
      void'($urandom(32'h458F));
      {rst_i, reg_wr_i, reg_rd_i, req_valid_i, slow, err, dirty} = 7'h40;
      {reg_addr_i, reg_wdata_i, req_i} = '0;
      ctrl = bre_ctrl_t'(CTRL_RESET);
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk({req_ready_o, cpl_valid_o, wz_may_unmap_o}, 3'h4);
      rdr(REG_CTRL);
      chk(rd, CTRL_RESET);
      rdr(8'h40);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wctrl(CTRL_RESET | (i[0] << 7));
         repeat (3) @(posedge mclk_i);
         chk(wz_may_unmap_o, ctrl.unmap_cap);
      end
      rdr(REG_STAT);
      chk({rd[2], rd[0]}, 2'h2);
      foreach (corner[k]) begin
         wctrl(corner[k][73:64]);
         // header fields travel as one unit ahead of data and status
         r = {corner[k][63:32], 64'h0123_4567_89AB_CDEF, 32'h8, corner[k][31:0], 16'h6, 32'h200};
         run(r);
      end
      for (int k = 0; k < 300; k++) begin
         // status word: op count, may-unmap, dirty, busy
         if (k % 8 == 0) begin
            rdr(REG_STAT);
            chk(rd, {be_cnt[15:0], 13'h0, ctrl.unmap_cap, dirty, 1'b0});
            wctrl(10'($urandom & 32'hFF));
         end
         slow        <= 1'($urandom % 2);
         err         <= ($urandom % 6) == 0;
         r.type_w    = types[$urandom % 9] | (($urandom % 4 == 0) ? 32'h8000_0000 : 32'h0);
         r.sector    = {$urandom, $urandom};
         r.nsect     = $urandom;
         r.seg_flags = ($urandom % 3 == 0) ? $urandom : $urandom % 2;
         r.cmd_len   = 16'($urandom);
         r.data_len  = 32'h200 + $urandom % 4096;
         run(r);
      end
      repeat (4) @(posedge mclk_i);
      chk(chg_cnt, tgl_cnt);
      test_done();
   end
endmodule
